// >>> wcs_weekly_cam_time_switch.sv
// Weekly cam time switch with an APB register file.
// Assumes rtc_time and scan_tick come from logic on pclk, scan_tick being
// a one-cycle pulse that marks each program scan.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps

// Function
// - Three cams each drive one switch output
// - Any weekday combination; cam acts only there
// - On-time match sets output unless already set
// - Off-time match clears output when configured
// - Pulse mode: output high one scan only
// - Single pulse setting governs all three cams
// - Conflicts: third beats second beats first
// - Output follows the latest switching action of any cam
// - Day mask ordered Monday through Sunday
// - Each day bit enables that day
// - Times span 00:00 to 23:59
// - Unset time performs no switching action
module wcs_weekly_cam_time_switch (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire wcs_pkg::wcs_time_t rtc_time,
  input  wire logic               scan_tick,
  output logic                    switch_out
);
  import wcs_pkg::*;

  wcs_state_t st_reg;
  wcs_state_t st_next;

  // True for any address that holds a register.
  function automatic logic addr_hit(input logic [7:0] addr);
    logic hit;
    hit = (addr == FIRST_CAM_SETTING_ADDR) ||
          (addr == SECOND_CAM_SETTING_ADDR) ||
          (addr == THIRD_CAM_SETTING_ADDR) ||
          (addr == CONTROL_ADDR) ||
          (addr == STATUS_ADDR);
    return hit;
  endfunction

  // Selects the day bit; bit 0 is Monday and bit 6 Sunday.
  function automatic logic day_sel(input logic [6:0] days,
                                   input logic [2:0] wday);
    logic sel;
    sel = 1'b0;
    if (wday <= LAST_DAY) begin
      sel = days[wday];
    end
    return sel;
  endfunction

  // A time out of range never matches, so it behaves as unset.
  function automatic logic time_hit(input logic       is_set,
                                    input logic [4:0] hour,
                                    input logic [5:0] minute,
                                    input wcs_time_t  now);
    logic hit;
    hit = is_set &&
          (hour <= MAX_HOUR) && (minute <= MAX_MINUTE) &&
          (hour == now.hour) && (minute == now.minute);
    return hit;
  endfunction

  function automatic logic [31:0] read_word(input wcs_state_t s,
                                            input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      FIRST_CAM_SETTING_ADDR: begin
        w = {1'b0, s.cam[0]};
      end
      SECOND_CAM_SETTING_ADDR: begin
        w = {1'b0, s.cam[1]};
      end
      THIRD_CAM_SETTING_ADDR: begin
        w = {1'b0, s.cam[2]};
      end
      CONTROL_ADDR: begin
        w[CTRL_PULSE_BIT] = s.pulse_en;
      end
      STATUS_ADDR: begin
        w[STAT_OUT_BIT] = s.switch_out;
        w[STAT_PULSE_BIT] = s.pulse_live;
        w[STAT_SYNC_BIT] = s.key_valid;
        w[STAT_WDAY_LSB +: 3] = s.last_key.weekday;
        w[STAT_HOUR_LSB +: 5] = s.last_key.hour;
        w[STAT_MINUTE_LSB +: 6] = s.last_key.minute;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  logic apb_setup;
  logic apb_write;
  logic new_minute;
  logic on_hit;
  logic off_hit;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && addr_hit(paddr);

  // A changed time key marks the first scan of a new minute, which keeps
  // a match from firing again on every later scan of the same minute.
  assign new_minute = !st_reg.key_valid || (st_reg.last_key != rtc_time);

  always_comb begin
    st_next = st_reg;
    on_hit = 1'b0;
    off_hit = 1'b0;

    // Read data and the error answer are prepared in the setup cycle so
    // that the access cycle can complete with no wait state.
    if (apb_setup) begin
      st_next.prdata = read_word(st_reg, paddr);
      st_next.pslverr = !addr_hit(paddr);
    end

    if (apb_write) begin
      case (paddr)
        FIRST_CAM_SETTING_ADDR: begin
          st_next.cam[0] = wcs_cam_t'(pwdata[30:0]);
        end
        SECOND_CAM_SETTING_ADDR: begin
          st_next.cam[1] = wcs_cam_t'(pwdata[30:0]);
        end
        THIRD_CAM_SETTING_ADDR: begin
          st_next.cam[2] = wcs_cam_t'(pwdata[30:0]);
        end
        CONTROL_ADDR: begin
          st_next.pulse_en = pwdata[CTRL_PULSE_BIT];
        end
        default: begin
          st_next.pulse_en = st_reg.pulse_en;
        end
      endcase
    end

    if (scan_tick) begin
      // A pulse lasts exactly the scan in which it was set.
      if (st_reg.pulse_live) begin
        st_next.switch_out = 1'b0;
        st_next.pulse_live = 1'b0;
      end

      if (new_minute) begin
        // Cams are applied in ascending order on one running output value,
        // so a later cam overrides an earlier one in the same minute.
        for (int i = 0; i < NUM_CAMS; i++) begin
          on_hit = day_sel(st_reg.cam[i].days, rtc_time.weekday) &&
                   time_hit(st_reg.cam[i].on_set, st_reg.cam[i].on_hour,
                            st_reg.cam[i].on_minute, rtc_time);
          off_hit = day_sel(st_reg.cam[i].days, rtc_time.weekday) &&
                    time_hit(st_reg.cam[i].off_set, st_reg.cam[i].off_hour,
                             st_reg.cam[i].off_minute, rtc_time);
          if (on_hit && !st_next.switch_out) begin
            st_next.switch_out = 1'b1;
            st_next.pulse_live = st_reg.pulse_en;
          end
          // Within one cam an identical off-time wins over its on-time.
          if (off_hit) begin
            st_next.switch_out = 1'b0;
            st_next.pulse_live = 1'b0;
          end
        end
      end

      st_next.key_valid = 1'b1;
      st_next.last_key = rtc_time;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.cam <= {NUM_CAMS{CAM_RESET}};
      st_reg.pulse_en <= PULSE_RESET;
      st_reg.switch_out <= 1'b0;
      st_reg.pulse_live <= 1'b0;
      st_reg.key_valid <= 1'b0;
      st_reg.last_key <= '0;
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign switch_out = st_reg.switch_out;

endmodule

// >>> wcs_pkg.sv
// Constants, field layouts and state types of the weekly cam time switch.
// Assumes a 40 MHz APB clock and a time-of-day source on the same clock.
package wcs_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  localparam int unsigned NUM_CAMS = 3;
  localparam int unsigned NUM_DAYS = 7;

  // Register byte addresses, one aligned word each.
  localparam logic [7:0] FIRST_CAM_SETTING_ADDR  = 8'h00;
  localparam logic [7:0] SECOND_CAM_SETTING_ADDR = 8'h04;
  localparam logic [7:0] THIRD_CAM_SETTING_ADDR  = 8'h08;
  localparam logic [7:0] CONTROL_ADDR            = 8'h0C;
  localparam logic [7:0] STATUS_ADDR             = 8'h10;

  // Range of a valid time of day.
  localparam logic [4:0] MAX_HOUR   = 5'h17;
  localparam logic [5:0] MAX_MINUTE = 6'h3B;
  localparam logic [2:0] LAST_DAY   = 3'h6;

  // Control and status bit positions.
  localparam int unsigned CTRL_PULSE_BIT   = 0;
  localparam int unsigned STAT_OUT_BIT     = 0;
  localparam int unsigned STAT_PULSE_BIT   = 1;
  localparam int unsigned STAT_SYNC_BIT    = 2;
  localparam int unsigned STAT_WDAY_LSB    = 8;
  localparam int unsigned STAT_HOUR_LSB    = 16;
  localparam int unsigned STAT_MINUTE_LSB  = 24;

  // Weekday 0 is Monday, 6 is Sunday.
  typedef struct packed {
    logic [2:0] weekday;
    logic [4:0] hour;
    logic [5:0] minute;
  } wcs_time_t;

  // One cam word, bit 0 upward: days, on set, on minute, on hour,
  // off set, off minute, off hour. Bit 31 is reserved.
  typedef struct packed {
    logic [4:0] off_hour;
    logic [5:0] off_minute;
    logic       off_set;
    logic [4:0] on_hour;
    logic [5:0] on_minute;
    logic       on_set;
    logic [6:0] days;
  } wcs_cam_t;

  localparam wcs_cam_t CAM_RESET   = '0;
  localparam logic     PULSE_RESET = 1'b0;

  typedef struct packed {
    wcs_cam_t [NUM_CAMS-1:0] cam;
    logic                    pulse_en;
    logic                    switch_out;
    logic                    pulse_live;
    logic                    key_valid;
    wcs_time_t               last_key;
    logic [31:0]             prdata;
    logic                    pslverr;
  } wcs_state_t;

endpackage

// >>> wcs_rtc_model.sv
// Time-of-day source with a scan pulse for the cam time switch bench.
// Assumes the bench raises go for one cycle per requested scan.
`timescale 1ns/100ps
module wcs_rtc_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              go,
  input  wire wcs_pkg::wcs_time_t t_in,
  output wcs_pkg::wcs_time_t      rtc_time,
  output logic                   scan_tick
);
  import wcs_pkg::*;
  // A real clock keeps showing its time between scans, so the time holds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_time  <= '0;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= go;
      if (go) begin
        rtc_time <= t_in;
      end
    end
  end
endmodule

// >>> wcs_props.sv
// Port checker of the weekly cam time switch.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module wcs_props (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire wcs_pkg::wcs_time_t rtc_time,
  input wire logic              scan_tick,
  input wire logic              switch_out
);
  import wcs_pkg::*;
  wcs_time_t last_reg;
  logic      seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
      last_reg <= '0;
    end else if (scan_tick) begin
      seen_reg <= 1'b1;
      last_reg <= rtc_time;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_tick_only: assert property (
    !scan_tick |=> $stable(switch_out)) else $error("output moved without a scan");
  a_same_min: assert property (
    scan_tick && seen_reg && rtc_time == last_reg && !switch_out |=> !switch_out)
    else $error("repeated minute switched on");
  a_bad_time: assert property (
    scan_tick && !switch_out && (rtc_time.hour > MAX_HOUR || rtc_time.minute > MAX_MINUTE)
    |=> !switch_out) else $error("invalid time switched on");
  a_stat_out: assert property (
    s_setup ##0 (!pwrite && paddr == STATUS_ADDR) |=> prdata[0] == $past(switch_out))
    else $error("status output bit wrong");
  a_err_map: assert property (
    s_setup ##0 (!pwrite && paddr > STATUS_ADDR) |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_ok_map: assert property (
    s_setup ##0 (paddr <= STATUS_ADDR && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped access refused");
  a_rsvd_zero: assert property (
    s_setup ##0 (!pwrite && paddr < CONTROL_ADDR) |=> !prdata[31])
    else $error("cam reserved bit set");
  a_ctrl_bits: assert property (
    s_setup ##0 (!pwrite && paddr == CONTROL_ADDR) |=> prdata[31:1] == 31'h0)
    else $error("control upper bits set");
endmodule
bind wcs_weekly_cam_time_switch wcs_props chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .rtc_time, .scan_tick, .switch_out);

// >>> wcs_weekly_cam_time_switch_tb.sv
// Bench of the weekly cam time switch: random cams against a reference.
// Assumes the APB slave and the scan source model share pclk.
`timescale 1ns/100ps
module wcs_weekly_cam_time_switch_tb;
  import wcs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, go, pready, pslverr;
  logic        switch_out, scan_tick, cur, pl, pen, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  wcs_time_t   t_in, rtc_time, tm, last;
  wcs_cam_t    cw [3];
  int          failures, checked, seed, i, p, n;
  int          cyc = 0;
  wcs_weekly_cam_time_switch dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rtc_time, .scan_tick, .switch_out);
  wcs_rtc_model rtc_u (.pclk, .presetn, .go, .t_in, .rtc_time, .scan_tick);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures = failures + 1;
      final_report();
    end
  end
  task automatic chk(input logic [32:0] g, x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d, e,
                    input logic ee);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    chk({pslverr, w ? 32'h0 : prdata}, {ee, w ? 32'h0 : e});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Minutes sit on a small grid so that cam times are hit often.
  function automatic wcs_time_t rt();
    rt.weekday = 3'($unsigned($random(seed)) % 7);
    rt.hour    = 5'(5 + $unsigned($random(seed)) % 3);
    rt.minute  = 6'(10 * ($unsigned($random(seed)) % 3));
  endfunction
  task automatic sc(input wcs_time_t t);
    @(posedge pclk);
    go   <= 1'b1;
    t_in <= t;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    if (pl) {cur, pl} = 2'b00;
    if (!seen || t !== last) begin
      foreach (cw[k]) begin
        if (cw[k].days[t.weekday] && cw[k].on_set && !cur &&
            {cw[k].on_hour, cw[k].on_minute} == {t.hour, t.minute}) {cur, pl} = {1'b1, pen};
        if (cw[k].days[t.weekday] && cw[k].off_set &&
            {cw[k].off_hour, cw[k].off_minute} == {t.hour, t.minute}) {cur, pl} = 2'b00;
      end
    end
    {seen, last} = {1'b1, t};
    chk({32'h0, switch_out}, {32'h0, cur});
  endtask
  initial begin
    {presetn, psel, penable, pwrite, go, cur, pl, pen, seen} = '0;
    {paddr, pwdata, t_in, last} = '0;
    {failures, checked} = '0;
    seed = 84;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) ap(1'b0, 8'(i * 4), 32'h0, 32'h0, i == 5);
    for (p = 0; p < 4; p++) begin
      for (i = 0; i < 3; i++) begin
        cw[i] = wcs_cam_t'(31'($random(seed)));
        tm = rt();
        {cw[i].on_hour, cw[i].on_minute} = {tm.hour, tm.minute};
        tm = rt();
        {cw[i].off_hour, cw[i].off_minute} = {tm.hour, tm.minute};
        ap(1'b1, 8'(i * 4), {1'b0, cw[i]}, 32'h0, 1'b0);
        ap(1'b0, 8'(i * 4), 32'h0, {1'b0, cw[i]}, 1'b0);
      end
      pen = p[0];
      ap(1'b1, CONTROL_ADDR, {31'($random(seed)), pen}, 32'h0, 1'b0);
      ap(1'b0, CONTROL_ADDR, 32'h0, {31'h0, pen}, 1'b0);
      ap(1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0, 1'b1);
      for (n = 0; n < 150; n++) begin
        tm = rt();
        if (n % 16 == 0) tm.hour = 5'h18;
        sc(tm);
        if (tm.minute == 6'h0) sc(tm);
      end
    end
    final_report();
  end
endmodule
